// File: lcdc_consts.svh
/*
 Constants of the segment LCD command decoder: bus address, command codes,
 setting bit positions, reset values and timing counts.
 Assumes it is included by its bare name wherever a constant is needed.
*/
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

// ****************************************************************
// Link
// ****************************************************************
`define LCDC_SLAVE_ADDR    7'h38
`define LCDC_RW_READ       1'b1

// ****************************************************************
// Command codes (first byte)
// ****************************************************************
`define LCDC_CMD_DISP      8'h80
`define LCDC_CMD_DRIVE     8'h82
`define LCDC_CMD_SYSTEM    8'h84
`define LCDC_CMD_FRAME     8'h86
`define LCDC_CMD_BLINK     8'h88

// ****************************************************************
// Setting byte fields
// ****************************************************************
`define LCDC_DUTY_BIT      1
`define LCDC_BIAS_BIT      0
`define LCDC_OSC_BIT       1
`define LCDC_DISP_BIT      0
`define LCDC_FRAME_BIT     0

// ****************************************************************
// Pointer range and reset values
// ****************************************************************
`define LCDC_PTR_RESET     4'h0
`define LCDC_LAST_QUARTER  4'h9
`define LCDC_LAST_EIGHTH   4'hF
`define LCDC_BLINK_OFF     2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define LCDC_CLK_HZ        125000000
`define LCDC_SYS_OSC_HZ    32000
`define LCDC_SYS_DIV       (`LCDC_CLK_HZ / `LCDC_SYS_OSC_HZ)
`define LCDC_BLINK_BITS    16

`endif

// File: lcdc_pkg.sv
/*
 Types of the segment LCD command decoder.
 Assumes lcdc_consts.svh supplies the numeric constants.
*/
package lcdc_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_RX   = 3'b010,
        ST_TX   = 3'b011,
        ST_SKIP = 3'b100
    } lcdc_state_t;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] data;
    } lcdc_wr_t;

    typedef struct packed
    {
        logic       duty_eighth;
        logic       bias_quarter;
        logic       osc_en;
        logic       disp_en;
        logic       frame_fast;
        logic [1:0] blink_rate;
    } lcdc_set_t;

endpackage

// File: lcdc_decoder.sv
/*
 Command decoder and display RAM access of a segment LCD controller,
 behind a two-wire serial slave port, plus its write FIFO.
 Assumes SCL and SDA arrive asynchronously and SDA is open drain
 (the outside resolves the wire from sda_oe_out).
*/
`timescale 1ns/10ps
`include "lcdc_consts.svh"

// ****************************************************************
// Write FIFO
// ****************************************************************
module lcdc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem[rd_q];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    always_ff @(posedge ref_clk_in)
    begin
        if (push)
            mem[wr_q] <= in_data_in;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ****************************************************************
// Decoder top
// ****************************************************************
module lcdc_decoder #(
    parameter int FIFO_DEPTH = 4,
    parameter int SYS_DIV    = `LCDC_SYS_DIV
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic            duty_eighth_out,
    output logic            bias_quarter_out,
    output logic            osc_en_out,
    output logic            disp_on_out,
    output logic            frame_fast_out,
    output logic [1:0]      blink_rate_out
);
    lcdc_pkg::lcdc_state_t state_q;
    lcdc_pkg::lcdc_set_t   set_q;
    lcdc_pkg::lcdc_wr_t    wr_word;
    lcdc_pkg::lcdc_wr_t    drain_word;
    logic [7:0]  ram [16];
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [3:0]  bit_cnt_q;
    logic [1:0]  byte_idx_q;
    logic [7:0]  sh_q;
    logic [7:0]  cmd_q;
    logic [3:0]  ptr_q;
    logic [3:0]  ptr_next;
    logic [3:0]  last_loc;
    logic        ack_clk;
    logic        cmd_known;
    logic        data_phase;
    logic        push;
    logic        fifo_ready;
    logic        drain_valid;
    logic        drain_ready;
    logic [11:0] drain_bits;
    logic [11:0] sys_cnt_q;
    logic        sys_tick;
    logic [`LCDC_BLINK_BITS-1:0] blink_cnt_q;
    logic        blink_phase;

    // ************************************************************
    // Pin synchronisers and bus conditions
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            scl_s <= 3'b111;
            sda_s <= 3'b111;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    // Only stages 1 and 2 are read; stage 0 is the metastable one
    assign scl_rise  = scl_s[1] & ~scl_s[2];
    assign scl_fall  = ~scl_s[1] & scl_s[2];
    assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
    assign ack_clk   = scl_rise & (bit_cnt_q == 4'h8);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    assign cmd_known = (cmd_q == `LCDC_CMD_DISP) |
                       (cmd_q == `LCDC_CMD_DRIVE) |
                       (cmd_q == `LCDC_CMD_SYSTEM) |
                       (cmd_q == `LCDC_CMD_FRAME) |
                       (cmd_q == `LCDC_CMD_BLINK);
    assign data_phase = (state_q == lcdc_pkg::ST_RX) &
                        (byte_idx_q == 2'd3) &
                        (cmd_q == `LCDC_CMD_DISP);
    assign last_loc = set_q.duty_eighth ? `LCDC_LAST_EIGHTH
                                        : `LCDC_LAST_QUARTER;
    assign ptr_next = (ptr_q == last_loc) ? `LCDC_PTR_RESET
                                          : ptr_q + 4'h1;
    assign push = ack_clk & data_phase;
    assign wr_word.addr = ptr_q;
    assign wr_word.data = sh_q;

    // ************************************************************
    // Byte framing state machine
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q    <= lcdc_pkg::ST_IDLE;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= 2'd0;
            sh_q       <= 8'h00;
            cmd_q      <= 8'h00;
        end
        else if (stop_det)
            state_q <= lcdc_pkg::ST_IDLE;
        else if (start_det)
        begin
            state_q    <= lcdc_pkg::ST_ADDR;
            bit_cnt_q  <= 4'h0;
            byte_idx_q <= 2'd0;
        end
        else if (scl_rise && state_q != lcdc_pkg::ST_IDLE)
        begin
            if (bit_cnt_q != 4'h8)
            begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (state_q != lcdc_pkg::ST_TX)
                    sh_q <= {sh_q[6:0], sda_s[2]};
                else
                    sh_q <= {sh_q[6:0], 1'b0};
            end
            else
            begin
                bit_cnt_q <= 4'h0;
                case (state_q)
                    lcdc_pkg::ST_ADDR:
                    begin
                        byte_idx_q <= 2'd1;
                        if (sh_q[7:1] != `LCDC_SLAVE_ADDR)
                            state_q <= lcdc_pkg::ST_SKIP;
                        else if (sh_q[0] == `LCDC_RW_READ)
                            state_q <= lcdc_pkg::ST_TX;
                        else
                            state_q <= lcdc_pkg::ST_RX;
                    end
                    lcdc_pkg::ST_RX:
                    begin
                        if (byte_idx_q == 2'd1)
                            cmd_q <= sh_q;
                        if (byte_idx_q != 2'd3)
                            byte_idx_q <= byte_idx_q + 2'd1;
                    end
                    lcdc_pkg::ST_TX:
                    begin
                        // Host NACK ends the burst; ACK keeps it going
                        if (sda_s[2])
                            state_q <= lcdc_pkg::ST_SKIP;
                    end
                    default:
                        state_q <= state_q;
                endcase
            end
        end
        else if (scl_fall && state_q == lcdc_pkg::ST_TX &&
                 bit_cnt_q == 4'h0)
            sh_q <= ram[ptr_q];
    end

    // ************************************************************
    // Open-drain data pin
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sda_out    <= 1'b0;
            sda_oe_out <= 1'b0;
        end
        else if (start_det || stop_det)
            sda_oe_out <= 1'b0;
        else if (scl_fall)
        begin
            if (state_q == lcdc_pkg::ST_TX && bit_cnt_q == 4'h0)
                sda_oe_out <= ~ram[ptr_q][7];
            else if (state_q == lcdc_pkg::ST_TX && bit_cnt_q != 4'h8)
                sda_oe_out <= ~sh_q[7];
            else if (bit_cnt_q == 4'h8 && state_q == lcdc_pkg::ST_ADDR)
                sda_oe_out <= (sh_q[7:1] == `LCDC_SLAVE_ADDR);
            else if (bit_cnt_q == 4'h8 && state_q == lcdc_pkg::ST_RX)
                // Full FIFO refuses the data byte with a NACK
                sda_oe_out <= ~data_phase | fifo_ready;
            else
                sda_oe_out <= 1'b0;
        end
    end

    // ************************************************************
    // Display RAM pointer
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            ptr_q <= `LCDC_PTR_RESET;
        else if (ack_clk && state_q == lcdc_pkg::ST_TX)
            ptr_q <= ptr_next;
        else if (push && fifo_ready)
            ptr_q <= ptr_next;
        else if (ack_clk && state_q == lcdc_pkg::ST_RX &&
                 byte_idx_q == 2'd2 && cmd_q == `LCDC_CMD_DISP)
            ptr_q <= sh_q[3:0];
    end

    // ************************************************************
    // Settings, applied on the acknowledge clock of the setting byte
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            set_q.duty_eighth  <= 1'b0;
            set_q.bias_quarter <= 1'b0;
            set_q.osc_en       <= 1'b0;
            set_q.disp_en      <= 1'b0;
            set_q.frame_fast   <= 1'b0;
            set_q.blink_rate   <= `LCDC_BLINK_OFF;
        end
        else if (ack_clk && state_q == lcdc_pkg::ST_RX &&
                 byte_idx_q == 2'd2 && cmd_known)
        begin
            case (cmd_q)
                `LCDC_CMD_DRIVE:
                begin
                    set_q.duty_eighth  <= sh_q[`LCDC_DUTY_BIT];
                    set_q.bias_quarter <= sh_q[`LCDC_BIAS_BIT];
                end
                `LCDC_CMD_SYSTEM:
                begin
                    set_q.osc_en  <= sh_q[`LCDC_OSC_BIT];
                    set_q.disp_en <= sh_q[`LCDC_DISP_BIT];
                end
                `LCDC_CMD_FRAME:
                    set_q.frame_fast <= sh_q[`LCDC_FRAME_BIT];
                `LCDC_CMD_BLINK:
                    set_q.blink_rate <= sh_q[1:0];
                default:
                    set_q <= set_q;
            endcase
        end
    end

    // ************************************************************
    // Write FIFO and RAM drain
    // ************************************************************
    // Drain pauses during reads so the read port sees a steady array
    assign drain_ready = (state_q != lcdc_pkg::ST_TX);
    assign drain_word  = lcdc_pkg::lcdc_wr_t'(drain_bits);

    lcdc_fifo #(
        .WIDTH (12),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .rstn_in       (rstn_in),
        .in_valid_in   (push),
        .in_ready_out  (fifo_ready),
        .in_data_in    (wr_word),
        .out_valid_out (drain_valid),
        .out_ready_in  (drain_ready),
        .out_data_out  (drain_bits)
    );

    always_ff @(posedge ref_clk_in)
    begin
        if (drain_valid && drain_ready)
            ram[drain_word.addr] <= drain_word.data;
    end

    // ************************************************************
    // System oscillator tick and blink divider
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            sys_cnt_q <= 12'h000;
        else if (!set_q.osc_en || sys_tick)
            sys_cnt_q <= 12'h000;
        else
            sys_cnt_q <= sys_cnt_q + 12'h001;
    end
    assign sys_tick = (sys_cnt_q == 12'(SYS_DIV - 1));

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            blink_cnt_q <= '0;
        else if (sys_tick)
            blink_cnt_q <= blink_cnt_q + 1'b1;
    end

    // Bit 13/14/15 toggles at fsys/16384, /32768, /65536
    always_comb
    begin
        case (set_q.blink_rate)
            2'h1:    blink_phase = blink_cnt_q[13];
            2'h2:    blink_phase = blink_cnt_q[14];
            2'h3:    blink_phase = blink_cnt_q[15];
            default: blink_phase = 1'b0;
        endcase
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            duty_eighth_out  <= 1'b0;
            bias_quarter_out <= 1'b0;
            osc_en_out       <= 1'b0;
            disp_on_out      <= 1'b0;
            frame_fast_out   <= 1'b0;
            blink_rate_out   <= 2'h0;
        end
        else
        begin
            duty_eighth_out  <= set_q.duty_eighth;
            bias_quarter_out <= set_q.bias_quarter;
            osc_en_out       <= set_q.osc_en;
            disp_on_out      <= set_q.osc_en & set_q.disp_en &
                                ~blink_phase;
            frame_fast_out   <= set_q.frame_fast;
            blink_rate_out   <= set_q.blink_rate;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    chk_ptr_wrap: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        ack_clk && state_q == lcdc_pkg::ST_TX && ptr_q == last_loc
        |=> ptr_q == 4'h0) else $error("pointer did not wrap");
    chk_ptr_adv: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        ack_clk && state_q == lcdc_pkg::ST_TX && ptr_q != last_loc
        |=> ptr_q == $past(ptr_q) + 4'h1) else $error("read advance");
    chk_ptr_load: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        ack_clk && state_q == lcdc_pkg::ST_RX && byte_idx_q == 2'd2 &&
        cmd_q == `LCDC_CMD_DISP |=> ptr_q == $past(sh_q[3:0]))
        else $error("pointer load");
    chk_addr_nack: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        scl_fall && bit_cnt_q == 4'h8 && state_q == lcdc_pkg::ST_ADDR &&
        sh_q[7:1] != `LCDC_SLAVE_ADDR |=> !sda_oe_out)
        else $error("acked wrong address");
    chk_tx_msb: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        scl_fall && state_q == lcdc_pkg::ST_TX && bit_cnt_q == 4'h0
        |=> sda_oe_out == !$past(ram[ptr_q][7]))
        else $error("first read bit wrong");
    chk_osc_gate: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !set_q.osc_en |=> !disp_on_out) else $error("display without osc");
    chk_setting_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !(ack_clk && state_q == lcdc_pkg::ST_RX) |=> $stable(set_q))
        else $error("setting changed without byte");
    chk_unknown_cmd: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        !cmd_known |=> $stable(set_q)) else $error("unknown cmd applied");
    chk_drive_set: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        ack_clk && state_q == lcdc_pkg::ST_RX && byte_idx_q == 2'd2 &&
        cmd_q == `LCDC_CMD_DRIVE |=> ##1 duty_eighth_out == $past(sh_q[1], 2))
        else $error("duty not applied");
    chk_blink_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        set_q.blink_rate == 2'h0 && set_q.osc_en && set_q.disp_en
        |=> disp_on_out) else $error("blanked without blink");
    chk_write_adv: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        push && fifo_ready |=> ptr_q == $past(ptr_next))
        else $error("write advance");
endmodule

// File: lcdc_host.sv
/*
 Host model of the two-wire bus: master driving SCL and open drain SDA.
 Assumes the bench resolves SDA with a pull-up from all drivers.
*/
`timescale 1ns/10ps
module lcdc_host (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out = 1'b1,
    output logic      sda_out = 1'b1
);
    // Four ref clocks a half period gives the 64 ns link period
    task automatic hp();
        repeat (4) @(posedge clk_in);
    endtask
    // Start when s is 1, stop when 0; SCL stays high after a stop
    task automatic cond(input logic s);
        hp();
        sda_out <= s;
        hp();
        scl_out <= 1'b1;
        hp();
        sda_out <= ~s;
        hp();
        scl_out <= ~s;
    endtask
    // SDA moves a clock after SCL falls, never with it
    task automatic bit_io(input logic b, output logic r);
        @(posedge clk_in);
        sda_out <= b;
        repeat (3) @(posedge clk_in);
        scl_out <= 1'b1;
        hp();
        r = sda_in;
        scl_out <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] w, input logic a9,
                        output logic [7:0] r, output logic ak);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(a9, ak);
    endtask
endmodule

// File: lcdc_decoder_tb.sv
/*
 Self-checking bench of the command decoder driven by a host model.
 Assumes lcdc_host drives SCL and SDA; SDA is pulled up here.
*/
`timescale 1ns/10ps
`include "lcdc_consts.svh"
module lcdc_decoder_tb;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic scl;
    logic hsda;
    logic sda_oe;
    logic ak;
    logic [7:0] rd;
    logic [7:0] d [4];
    logic [31:0] seed = 32'h0000_0015;
    lcdc_pkg::lcdc_set_t e = '0;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    logic lit;
    // Fast oscillator tick so a whole blink half period fits the run
    localparam int SYS_DIV_TB = 2;
    // 2 Hz is fsys/16384: each lit or dark half lasts 8192 ticks
    localparam int BLINK_HALF = 8192 * SYS_DIV_TB;
    wire dsda;
    wire duty_o;
    wire bias_o;
    wire osc_o;
    wire disp_o;
    wire frame_o;
    wire [1:0] blink_o;
    // Pull-up: the device only pulls low when it enables its driver
    wire sda = hsda & (~sda_oe | dsda);
    always #4 ref_clk_in = ~ref_clk_in;
    lcdc_host lcdc_host_inst (.clk_in(ref_clk_in), .sda_in(sda),
        .scl_out(scl), .sda_out(hsda));
    lcdc_decoder #(.SYS_DIV(SYS_DIV_TB)) lcdc_decoder_inst (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl),
        .sda_in(sda), .sda_out(dsda), .sda_oe_out(sda_oe),
        .duty_eighth_out(duty_o), .bias_quarter_out(bias_o),
        .osc_en_out(osc_o), .disp_on_out(disp_o),
        .frame_fast_out(frame_o), .blink_rate_out(blink_o));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        num_checks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("MISMATCH %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic cs();
        chk({dsda, duty_o, bias_o, osc_o, disp_o, frame_o, blink_o},
            {1'b0, e.duty_eighth, e.bias_quarter, e.osc_en,
            e.osc_en & e.disp_en, e.frame_fast, e.blink_rate});
    endtask
    task automatic wr(input logic [7:0] b, input logic want);
        lcdc_host_inst.xfer(b, 1'b1, rd, ak);
        chk({7'h00, ak}, {7'h00, want});
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] v);
        lcdc_host_inst.cond(1'b1);
        wr(8'h70, 1'b0);
        wr(c, 1'b0);
        wr(v, 1'b0);
        lcdc_host_inst.cond(1'b0);
        case (c)
            `LCDC_CMD_DRIVE: {e.duty_eighth, e.bias_quarter} = v[1:0];
            `LCDC_CMD_SYSTEM: {e.osc_en, e.disp_en} = v[1:0];
            `LCDC_CMD_FRAME: e.frame_fast = v[0];
            `LCDC_CMD_BLINK: e.blink_rate = v[1:0];
            default: ;
        endcase
        cs();
    endtask
    task automatic end_of_test();
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        cs();
        for (int i = 0; i < 24; i++)
        begin
            seed = xs(seed);
            cmd((i % 6 == 5) ? 8'h8A : 8'h82 + 8'(2 * (i % 4)), seed[7:0]);
        end
        lcdc_host_inst.cond(1'b1);
        wr(8'h72, 1'b1);
        // Foreign address: the rest of the transfer goes unanswered
        wr(8'h84, 1'b1);
        lcdc_host_inst.cond(1'b1);
        wr(8'h70, 1'b0);
        wr(8'h84, 1'b0);
        // STOP at the 8th clock; a 9th rise would be the ack clock
        repeat (7) lcdc_host_inst.bit_io(~e.osc_en, ak);
        lcdc_host_inst.cond(1'b0);
        cs();
        cmd(8'h82, 8'h00);
        lcdc_host_inst.cond(1'b1);
        wr(8'h70, 1'b0);
        wr(`LCDC_CMD_DISP, 1'b0);
        wr(8'h38, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            d[k] = seed[15:8];
            wr(d[k], 1'b0);
        end
        lcdc_host_inst.cond(1'b1);
        wr(8'h70, 1'b0);
        wr(`LCDC_CMD_DISP, 1'b0);
        wr(8'hF8, 1'b0);
        lcdc_host_inst.cond(1'b1);
        wr(8'h71, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            lcdc_host_inst.xfer(8'hFF, k == 3, rd, ak);
            chk(rd, d[k]);
        end
        lcdc_host_inst.cond(1'b0);
        cmd(8'h84, 8'h03);
        cmd(8'h88, 8'h01);
        lit = disp_o;
        n = 0;
        while (disp_o == lit && n < 20000)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        lit = disp_o;
        n = 0;
        while (disp_o == lit && n < 20000)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        chk({7'h00, n == BLINK_HALF}, 8'h01);
        // Reset in mid-run must bring back every power-on setting
        rstn_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        e = '0;
        repeat (4) @(posedge ref_clk_in);
        cs();
        end_of_test();
    end
    initial
    begin
        repeat (100000) @(posedge ref_clk_in);
        mismatches++;
        end_of_test();
    end
endmodule
